// >>> llm_params.svh
`ifndef LLM_PARAMS_SVH
`define LLM_PARAMS_SVH

`define LLM_ADDR_SEL         12'h000
`define LLM_ADDR_LIMIT_LO    12'h004
`define LLM_ADDR_LIMIT_HI    12'h008
`define LLM_ADDR_PSE_LO      12'h00c
`define LLM_ADDR_PSE_HI      12'h010
`define LLM_ADDR_COUNT       12'h014
`define LLM_ADDR_LAST_ADDR   12'h018
`define LLM_ADDR_LAST_LAT    12'h01c
`define LLM_ADDR_LAST_SRC    12'h020
`define LLM_ADDR_SAV         12'h024
`define LLM_ADDR_REMAIN      12'h028
`define LLM_ADDR_LFSR_SEED   12'h02c

`define LLM_SLOW_LOAD_SEL    16'h0100
`define LLM_COUNT_MASK_FIELD_LSB        24
`define LLM_INV_BIT          23
`define LLM_LIMIT_RESET      16'h0000
`define LLM_SRC_UNCACHEABLE  4'hf
`define LLM_LFSR_RESET       16'hace1
`define LLM_LFSR_TAPS        16'hb400
`define LLM_TAG_MASK_RESET   4'h3
`define LLM_SAV_RESET        32'h0000_0001

`endif

// >>> llm_pkg.sv
package llm_pkg;
  typedef enum logic [1:0] {
    LLM_IDLE,
    LLM_TRACK,
    LLM_DONE
  } llm_track_e;
  typedef logic [15:0] llm_lat_t;
  typedef logic [3:0]  llm_src_t;
endpackage

// >>> llm_lfsr.sv
`timescale 1ns/10ps
`include "llm_params.svh"
module llm_lfsr (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        seed_load,
  input  wire logic [15:0] seed,
  input  wire logic        step,
  output logic      [15:0] value
);
  logic [15:0] lfsr_reg;
  logic [15:0] lfsr_next;

  always_comb begin
    lfsr_next = lfsr_reg;
    if (seed_load) begin
      lfsr_next = (seed == 16'h0000) ? `LLM_LFSR_RESET : seed;
    end else if (step) begin
      lfsr_next = (lfsr_reg >> 1) ^ (lfsr_reg[0] ? `LLM_LFSR_TAPS : 16'h0000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_reg <= `LLM_LFSR_RESET;
    end else begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign value = lfsr_reg;
endmodule

// >>> llm_sample_mem.sv
`timescale 1ns/10ps
module llm_sample_mem (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        wr_en,
  input  wire logic [63:0] wr_addr,
  input  wire logic [15:0] wr_lat,
  input  wire logic [3:0]  wr_src,
  output logic      [63:0] rd_addr,
  output logic      [15:0] rd_lat,
  output logic      [3:0]  rd_src
);
  // Holds the last load written on wr_en (tagged, retired, visible, above the limit); read data is registered
  logic [83:0] rec_reg;
  logic [83:0] rec_next;

  always_comb begin
    rec_next = rec_reg;
    if (wr_en) begin
      rec_next = {wr_addr, wr_lat, wr_src};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rec_reg <= 84'h0;
    end else begin
      rec_reg <= rec_next;
    end
  end

  assign rd_addr = rec_reg[83:20];
  assign rd_lat  = rec_reg[19:4];
  assign rd_src  = rec_reg[3:0];
endmodule

// >>> llm_monitor.sv
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/10ps
`include "llm_params.svh"
module llm_monitor (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ld_dispatch,
  input  wire logic        ld_is_store,
  input  wire logic        ld_is_demand,
  input  wire logic [63:0] ld_lin_addr,
  input  wire logic        ld_data_ret,
  input  wire logic [3:0]  ld_src,
  input  wire logic        ld_retire,
  input  wire logic        ld_visible,
  output logic             assist_req,
  output logic [63:0]      rec_lin_addr,
  output logic [15:0]      rec_latency,
  output logic [3:0]       rec_src
);
  // Selector, limit and enable for general counter 0 only
  logic [31:0] sel_reg, sel_next;
  logic [63:0] limit_reg, limit_next;
  logic [63:0] pse_reg, pse_next;
  logic [31:0] count_reg, count_next;
  logic [31:0] sav_reg, sav_next;
  logic [31:0] remain_reg, remain_next;
  logic [31:0] prdata_reg, prdata_next;
  logic        pready_reg, pready_next;
  logic        pslverr_reg, pslverr_next;
  logic        assist_reg, assist_next;
  logic [63:0] out_addr_reg, out_addr_next;
  logic [15:0] out_lat_reg, out_lat_next;
  logic [3:0]  out_src_reg, out_src_next;
  llm_pkg::llm_track_e st_reg, st_next;
  llm_pkg::llm_lat_t   lat_reg, lat_next;
  llm_pkg::llm_src_t   src_reg, src_next;
  logic [63:0] addr_reg, addr_next;
  logic        pending_reg, pending_next;

  logic        wr_acc, rd_acc;
  logic        seed_load;
  logic [15:0] lfsr_val;
  logic        mem_wr;
  logic [63:0] mem_addr;
  logic [15:0] mem_lat;
  logic [3:0]  mem_src;
  logic        sel_slow, ll_active, tag_hit, above, retire_tagged;
  logic [31:0] limit_wr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  // Access phase takes one wait state; registered pready then pulses for one cycle
  assign wr_acc = psel && penable && pwrite && !pready_reg;
  assign rd_acc = psel && penable && !pwrite && !pready_reg;
  assign seed_load = wr_acc && (paddr == `LLM_ADDR_LFSR_SEED);
  assign limit_wr  = merge({16'h0, limit_reg[15:0]}, pwdata, pstrb);

  // Count mask and invert assumed zero by software
  assign sel_slow  = (sel_reg[15:0] == `LLM_SLOW_LOAD_SEL);
  assign ll_active = pse_reg[0] && pse_reg[32] && sel_slow;
  // Tag roughly one dispatch in four with the fixed two-bit mask
  assign tag_hit = (lfsr_val[3:0] & `LLM_TAG_MASK_RESET) == 4'h0;
  assign above = lat_reg > limit_reg[15:0];
  assign retire_tagged = ld_retire && (st_reg == llm_pkg::LLM_DONE);

  llm_lfsr u_lfsr (
    .pclk      (pclk),
    .presetn   (presetn),
    .seed_load (seed_load),
    .seed      (pwdata[15:0]),
    .step      (ld_dispatch),
    .value     (lfsr_val)
  );

  // Tracker: one tagged load in flight at a time
  always_comb begin
    st_next  = st_reg;
    lat_next = lat_reg;
    src_next = src_reg;
    addr_next = addr_reg;
    case (st_reg)
      llm_pkg::LLM_IDLE: begin
        // Stores and prefetches are never tagged
        if (ll_active && ld_dispatch && !ld_is_store && ld_is_demand
            && tag_hit) begin
          st_next   = llm_pkg::LLM_TRACK;
          lat_next  = 16'h0001;
          addr_next = ld_lin_addr;
        end
      end
      llm_pkg::LLM_TRACK: begin
        // Re-dispatches keep counting; start is the first dispatch
        if (ld_data_ret) begin
          st_next  = llm_pkg::LLM_DONE;
          src_next = ld_src;
        end else begin
          lat_next = sat_inc(lat_reg);
        end
      end
      llm_pkg::LLM_DONE: begin
        if (ld_retire) begin
          st_next = llm_pkg::LLM_IDLE;
        end
      end
      default: st_next = llm_pkg::LLM_IDLE;
    endcase
    if (!ll_active) begin
      st_next = llm_pkg::LLM_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg   <= llm_pkg::LLM_IDLE;
      lat_reg  <= 16'h0000;
      src_reg  <= 4'h0;
      addr_reg <= 64'h0;
    end else begin
      st_reg   <= st_next;
      lat_reg  <= lat_next;
      src_reg  <= src_next;
      addr_reg <= addr_next;
    end
  end

  // Only retired visible loads above the limit are recorded
  assign mem_wr = retire_tagged && ld_visible && above;

  llm_sample_mem u_mem (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (mem_wr),
    .wr_addr (addr_reg),
    .wr_lat  (lat_reg),
    .wr_src  (src_reg),
    .rd_addr (mem_addr),
    .rd_lat  (mem_lat),
    .rd_src  (mem_src)
  );

  // Counting, sample-after and assist
  always_comb begin
    count_next    = count_reg;
    remain_next   = remain_reg;
    assist_next   = 1'b0;
    pending_next  = pending_reg;
    out_addr_next = out_addr_reg;
    out_lat_next  = out_lat_reg;
    out_src_next  = out_src_reg;
    if (mem_wr) begin
      count_next = count_reg + 32'h0000_0001;
      // Reload counts samples, not raw tags
      if (remain_reg <= 32'h0000_0001) begin
        remain_next  = sav_reg;
        pending_next = 1'b1;
      end else begin
        remain_next = remain_reg - 32'h0000_0001;
      end
    end
    // Assist sees the record one cycle after it is written
    if (pending_reg && !mem_wr) begin
      assist_next   = 1'b1;
      pending_next  = 1'b0;
      out_addr_next = mem_addr;
      out_lat_next  = mem_lat;
      out_src_next  = mem_src;
    end
    if (wr_acc && paddr == `LLM_ADDR_COUNT) begin
      count_next = merge(count_reg, pwdata, pstrb);
    end
    if (wr_acc && paddr == `LLM_ADDR_REMAIN) begin
      remain_next = merge(remain_reg, pwdata, pstrb);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg    <= 32'h0;
      remain_reg   <= `LLM_SAV_RESET;
      assist_reg   <= 1'b0;
      pending_reg  <= 1'b0;
      out_addr_reg <= 64'h0;
      out_lat_reg  <= 16'h0;
      out_src_reg  <= 4'h0;
    end else begin
      count_reg    <= count_next;
      remain_reg   <= remain_next;
      assist_reg   <= assist_next;
      pending_reg  <= pending_next;
      out_addr_reg <= out_addr_next;
      out_lat_reg  <= out_lat_next;
      out_src_reg  <= out_src_next;
    end
  end

  // Register file over APB
  always_comb begin
    sel_next     = sel_reg;
    limit_next   = limit_reg;
    pse_next     = pse_reg;
    sav_next     = sav_reg;
    prdata_next  = prdata_reg;
    pready_next  = psel && penable && !pready_reg;
    pslverr_next = 1'b0;
    if (wr_acc) begin
      case (paddr)
        `LLM_ADDR_SEL:       sel_next = merge(sel_reg, pwdata, pstrb);
        // Upper limit bits are reserved and stay zero
        `LLM_ADDR_LIMIT_LO:  limit_next[15:0] = limit_wr[15:0];
        `LLM_ADDR_LIMIT_HI:  limit_next = limit_reg;
        `LLM_ADDR_PSE_LO:    pse_next[31:0] = merge(pse_reg[31:0],
                               pwdata, pstrb);
        `LLM_ADDR_PSE_HI:    pse_next[63:32] = merge(pse_reg[63:32],
                               pwdata, pstrb);
        `LLM_ADDR_SAV:       sav_next = merge(sav_reg, pwdata, pstrb);
        `LLM_ADDR_COUNT, `LLM_ADDR_REMAIN, `LLM_ADDR_LFSR_SEED: begin
        end
        `LLM_ADDR_LAST_ADDR, `LLM_ADDR_LAST_LAT,
        `LLM_ADDR_LAST_SRC:  pslverr_next = 1'b1;
        default:             pslverr_next = 1'b1;
      endcase
    end
    if (rd_acc) begin
      case (paddr)
        `LLM_ADDR_SEL:       prdata_next = sel_reg;
        `LLM_ADDR_LIMIT_LO:  prdata_next = limit_reg[31:0];
        `LLM_ADDR_LIMIT_HI:  prdata_next = limit_reg[63:32];
        `LLM_ADDR_PSE_LO:    prdata_next = pse_reg[31:0];
        `LLM_ADDR_PSE_HI:    prdata_next = pse_reg[63:32];
        `LLM_ADDR_COUNT:     prdata_next = count_reg;
        `LLM_ADDR_LAST_ADDR: prdata_next = out_addr_reg[31:0];
        `LLM_ADDR_LAST_LAT:  prdata_next = {16'h0, out_lat_reg};
        `LLM_ADDR_LAST_SRC:  prdata_next = {28'h0, out_src_reg};
        `LLM_ADDR_SAV:       prdata_next = sav_reg;
        `LLM_ADDR_REMAIN:    prdata_next = remain_reg;
        `LLM_ADDR_LFSR_SEED: prdata_next = {16'h0, lfsr_val};
        default: begin
          prdata_next  = 32'h0;
          pslverr_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_reg     <= 32'h0;
      limit_reg   <= {48'h0, `LLM_LIMIT_RESET};
      pse_reg     <= 64'h0;
      sav_reg     <= `LLM_SAV_RESET;
      prdata_reg  <= 32'h0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      sel_reg     <= sel_next;
      limit_reg   <= limit_next;
      pse_reg     <= pse_next;
      sav_reg     <= sav_next;
      prdata_reg  <= prdata_next;
      pready_reg  <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign assist_req   = assist_reg;
  assign rec_lin_addr = out_addr_reg;
  assign rec_latency  = out_lat_reg;
  assign rec_src      = out_src_reg;
endmodule

// >>> llm_monitor_asserts.sv
`timescale 1ns/10ps
module llm_monitor_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        ld_retire,
  input wire logic        ld_visible,
  input wire logic        assist_req,
  input wire logic [63:0] rec_lin_addr,
  input wire logic [15:0] rec_latency,
  input wire logic [3:0]  rec_src
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable && !pready;
  a_one_wait: assert property (acc |=> pready)
    else $error("pready not after one wait");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_unmapped_err: assert property (acc && paddr > 12'h02c
    |=> pslverr && ($past(pwrite) || prdata == 32'h0))
    else $error("unmapped not refused");
  a_ro_write: assert property (acc && pwrite &&
    (paddr == 12'h018 || paddr == 12'h01c || paddr == 12'h020) |=> pslverr)
    else $error("record write not refused");
  a_assist_cause: assert property (assist_req |->
    $past(ld_retire, 2) && $past(ld_visible, 2))
    else $error("assist without retire");
  a_assist_pulse: assert property (assist_req |=> !assist_req)
    else $error("assist longer than one cycle");
  a_min_lat: assert property (assist_req |-> rec_latency > 16'h3)
    else $error("reported latency too small");
  a_rec_hold: assert property (!assist_req |->
    $stable(rec_latency) && $stable(rec_src) && $stable(rec_lin_addr))
    else $error("record changed without assist");
  c_assist: cover property (assist_req);
  c_err: cover property (pslverr);
  c_read: cover property (pready && !pwrite);
endmodule
bind llm_monitor llm_monitor_asserts u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ld_retire(ld_retire), .ld_visible(ld_visible), .assist_req(assist_req),
  .rec_lin_addr(rec_lin_addr), .rec_latency(rec_latency), .rec_src(rec_src));

// >>> test_load_latency_monitor.sv
`timescale 1ns/10ps
`include "llm_params.svh"
module test_load_latency_monitor;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  pstrb = 4'h0, ld_src = 4'h0, rec_src, r_src;
  logic        pready, pslverr, assist_req, ld_dispatch = 0;
  logic        ld_is_store = 0, ld_is_demand = 0, ld_visible = 0;
  logic        ld_data_ret = 0, ld_retire = 0;
  logic [63:0] ld_lin_addr = 64'h0, rec_lin_addr, r_addr;
  logic [15:0] rec_latency, r_lat;
  int          fail_count = 0, checks = 0, assists = 0, cyc = 0;
  int          seed = 37, lim = 5, c, last_k = 0;
  logic [3:0]  last_s = 4'h0;
  logic [31:0] last_a = 32'h0;
  llm_monitor dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ld_dispatch(ld_dispatch), .ld_is_store(ld_is_store),
    .ld_is_demand(ld_is_demand), .ld_lin_addr(ld_lin_addr),
    .ld_data_ret(ld_data_ret), .ld_src(ld_src), .ld_retire(ld_retire),
    .ld_visible(ld_visible), .assist_req(assist_req),
    .rec_lin_addr(rec_lin_addr), .rec_latency(rec_latency),
    .rec_src(rec_src));
  always #5 pclk = ~pclk;
  // Record outputs rise with assist_req, so sample them together
  always @(posedge pclk) begin
    cyc++;
    if (assist_req === 1'b1) begin
      assists++;
      r_addr = rec_lin_addr;
      r_lat = rec_latency;
      r_src = rec_src;
    end
    if (cyc == 30000) begin
      fail_count++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input bit w, input logic [11:0] a,
                     input logic [31:0] d, input bit ee, input bit cd = 1,
                     input logic [3:0] be = 4'hf);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    pstrb <= be;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    chk("pready", 1, pready);
    if (!w && cd) chk("prdata", d, prdata);
    chk("pslverr", ee, pslverr);
    psel <= 0; penable <= 0;
  endtask
  task automatic ld(input bit st, dm, vis, input int k, input bit act);
    logic [63:0] a;
    logic [3:0]  s;
    int          n0;
    bit          el;
    a = {$random(seed), $random(seed)};
    s = $random(seed);
    el = act && !st && dm && vis && k > lim;
    n0 = assists;
    @(posedge pclk);
    ld_dispatch <= 1; ld_is_store <= st; ld_is_demand <= dm;
    ld_lin_addr <= a; ld_visible <= vis;
    @(posedge pclk);
    ld_dispatch <= 0;
    repeat (k - 1) @(posedge pclk);
    ld_data_ret <= 1; ld_src <= s;
    @(posedge pclk);
    ld_data_ret <= 0; ld_retire <= 1;
    @(posedge pclk);
    ld_retire <= 0;
    repeat (4) @(posedge pclk);
    if (!el) chk("assist", 0, assists - n0);
    else if (assists != n0) begin
      chk("rec_latency", k, r_lat);
      chk("rec_src", s, r_src);
      chk("rec_lin_addr", a, r_addr);
      last_k = k;
      last_s = s;
      last_a = a[31:0];
    end
  endtask
  // Six load kinds; only the first two may be counted
  task automatic run(input int n, input bit act);
    for (int i = 0; i < n; i++)
      case (i % 6)
        0, 1: ld(0, 1, 1, lim + 1 + (i % 4), act);
        2: ld(0, 1, 1, lim, act);
        3: ld(1, 1, 1, lim + 3, act);
        4: ld(0, 0, 1, lim + 3, act);
        default: ld(0, 1, 0, lim + 3, act);
      endcase
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    apb(0, 12'h004, 32'h0, 0);
    apb(0, 12'h008, 32'h0, 0);
    apb(0, 12'h014, 32'h0, 0);
    apb(0, 12'h024, 32'h1, 0);
    apb(1, 12'h024, 32'hffff_ff01, 0, 1, 4'h1);
    apb(0, 12'h024, 32'h1, 0);
    apb(1, 12'h02c, 32'h1234, 0);
    apb(0, 12'h02c, 32'h1234, 0);
    apb(1, 12'h02c, 32'h0, 0);
    apb(0, 12'h02c, {16'h0, `LLM_LFSR_RESET}, 0);
    apb(0, 12'h0fc, 32'h0, 1);
    apb(1, 12'h0fc, 32'h1, 1);
    apb(1, 12'h01c, 32'h1, 1);
    apb(1, 12'h004, 32'h5, 0);
    apb(0, 12'h004, 32'h5, 0);
    apb(1, 12'h000, 32'h0101, 0);
    apb(1, 12'h00c, 32'h1, 0);
    apb(1, 12'h010, 32'h1, 0);
    $display("test registers done");
    run(12, 0);
    apb(1, 12'h000, 32'h0100, 0);
    apb(1, 12'h010, 32'h0, 0);
    run(12, 0);
    $display("test gating done");
    apb(1, 12'h010, 32'h1, 0);
    run(60, 1);
    c = assists;
    apb(0, 12'h014, c, 0);
    chk("tagged", 1, c > 0);
    apb(0, 12'h018, last_a, 0);
    apb(0, 12'h01c, last_k, 0);
    apb(0, 12'h020, last_s, 0);
    $display("test counting done");
    apb(1, 12'h024, 32'h3, 0);
    apb(1, 12'h028, 32'h3, 0);
    apb(1, 12'h014, 32'h0, 0);
    c = assists;
    run(120, 1);
    apb(0, 12'h014, 32'h0, 0, 0);
    chk("assists", q / 3, assists - c);
    apb(0, 12'h028, 3 - q % 3, 0);
    $display("test sample after done");
    end_of_test();
  end
endmodule
